/* core/tgc_map.svh */
// Register offsets, field positions and reset values of the timer control.
// Assumes 32-bit AXI4-Lite data with each register on an aligned word.
`ifndef TGC_MAP_SVH
`define TGC_MAP_SVH

// ==========================================================
// Address map
`define TGC_ADDR_W 8
`define TGC_OFF_GCTRL 8'h00
`define TGC_OFF_UCNT 8'h04
`define TGC_OFF_UPRD 8'h08
`define TGC_OFF_UENA 8'h0c
`define TGC_OFF_STAT 8'h10

// ==========================================================
// Field positions
`define TGC_PSCNT_LSB 12
`define TGC_PSLIM_LSB 8
`define TGC_MODE_LSB 2
`define TGC_URUN_BIT 1
`define TGC_LRUN_BIT 0
`define TGC_UENA_LSB 0

// ==========================================================
// Reset values
`define TGC_PSLIM_RST 4'h0
`define TGC_UCNT_RST 32'h0000_0000
`define TGC_UPRD_RST 32'h0000_0000

// ==========================================================
// Bus responses
`define TGC_RESP_OKAY 2'b00
`define TGC_RESP_SLVERR 2'b10

`endif

/* core/tgc_pkg.sv */
// Types shared by the timer control modules.
// Assumes the map header supplies all numeric constants.
package tgc_pkg;

  // ==========================================================
  // Timer modes and upper enable modes
  typedef enum logic [1:0] {
    TGC_MODE_GP64       = 2'b00,
    TGC_MODE_DUAL_UNCH  = 2'b01,
    TGC_MODE_WDOG64     = 2'b10,
    TGC_MODE_DUAL_CHAIN = 2'b11
  } tgc_mode_e;

  typedef enum logic [1:0] {
    TGC_ENA_OFF  = 2'b00,
    TGC_ENA_ONCE = 2'b01,
    TGC_ENA_CONT = 2'b10,
    TGC_ENA_RSVD = 2'b11
  } tgc_ena_e;

endpackage

/* core/tgc_axil.sv */
// AXI4-Lite slave front end: turns channel handshakes into register strobes.
// Assumes the parent decodes addresses and returns read data combinationally.
`include "tgc_map.svh"

module tgc_axil (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`TGC_ADDR_W-1:0] awaddr,
  input  wire logic                   awvalid,
  output wire logic                   awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output wire logic                   wready,
  output logic      [1:0]             bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [`TGC_ADDR_W-1:0] araddr,
  input  wire logic                   arvalid,
  output wire logic                   arready,
  output logic      [31:0]            rdata,
  output logic      [1:0]             rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  output wire logic                   wr_en,
  output logic      [`TGC_ADDR_W-1:0] wr_addr,
  output logic      [31:0]            wr_data,
  output logic      [3:0]             wr_strb,
  input  wire logic                   wr_hit,
  input  wire logic [31:0]            rd_data,
  input  wire logic                   rd_hit
);

  logic aw_held;
  logic w_held;

  // ==========================================================
  // Handshake decode
  // Address and data may arrive in either order; both are parked first
  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign wr_en   = aw_held && w_held && !bvalid;
  assign arready = !rvalid;

  // ==========================================================
  // Write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `TGC_RESP_OKAY;
      wr_addr <= '0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held  <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_en) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_hit ? `TGC_RESP_OKAY : `TGC_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `TGC_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_hit ? rd_data : 32'h0000_0000;
      rresp  <= rd_hit ? `TGC_RESP_OKAY : `TGC_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

/* core/tgc_prescale.sv */
// Four-bit linear prescaler for the upper half of the timer.
// Assumes en and clr come from logic on the same clock.
module tgc_prescale #(
  parameter int W = 4
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         en,
  input  wire logic         clr,
  input  wire logic [W-1:0] limit,
  output logic      [W-1:0] count,
  output logic              tick
);

  logic match;

  assign match = en && (count == limit);

  // ==========================================================
  // Prescale counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (clr) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= match ? '0 : (en ? W'(count + 1'b1) : count);
      tick  <= match;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence ps_match_s;
    en && !clr && (count == limit);
  endsequence

  ps_advance_a: assert property (
    en && !clr && (count != limit) |=> count == W'($past(count) + 1'b1))
    else $error("prescale count did not advance");

  ps_wrap_a: assert property (
    ps_match_s |=> (count == '0) && tick)
    else $error("prescale count did not wrap after match");

  ps_clear_a: assert property (
    clr |=> (count == '0) && !tick)
    else $error("prescale count not held at zero in reset");

endmodule

/* core/tgc_top.sv */
// Global control of a 64-bit timer: mode, run bits, upper-half prescaler.
// Assumes wdog_active comes from the watchdog logic on the same clock.
`include "tgc_map.svh"

module tgc_top
  import tgc_pkg::*;
#(
  parameter int PS_W = 4
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`TGC_ADDR_W-1:0] awaddr,
  input  wire logic                   awvalid,
  output wire logic                   awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output wire logic                   wready,
  output wire logic [1:0]             bresp,
  output wire logic                   bvalid,
  input  wire logic                   bready,
  input  wire logic [`TGC_ADDR_W-1:0] araddr,
  input  wire logic                   arvalid,
  output wire logic                   arready,
  output wire logic [31:0]            rdata,
  output wire logic [1:0]             rresp,
  output wire logic                   rvalid,
  input  wire logic                   rready,
  input  wire logic                   wdog_active,
  output tgc_pkg::tgc_mode_e          timer_mode,
  output wire logic                   lower_run,
  output wire logic                   upper_run,
  output wire logic [31:0]            upper_count,
  output wire logic                   upper_stopped
);

  import tgc_pkg::*;

  // ==========================================================
  // Decode helpers
  function automatic logic is_mapped(input logic [`TGC_ADDR_W-1:0] a);
    is_mapped = (a == `TGC_OFF_GCTRL) || (a == `TGC_OFF_UCNT) ||
                (a == `TGC_OFF_UPRD)  || (a == `TGC_OFF_UENA) ||
                (a == `TGC_OFF_STAT);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // ==========================================================
  // Declarations
  logic                   wr_en;
  logic [`TGC_ADDR_W-1:0] wr_addr;
  logic [31:0]            wr_data;
  logic [3:0]             wr_strb;
  logic [31:0]            rd_data;
  logic                   wr_hit;
  logic                   rd_hit;

  logic [PS_W-1:0] pslim_reg;
  tgc_mode_e       mode_reg;
  logic            urun_reg;
  logic            lrun_reg;
  logic [31:0]     uprd_reg;
  tgc_ena_e        uena_reg;
  logic [31:0]     ucnt_reg;
  logic [31:0]     ucnt_next;
  logic            ustop_reg;
  logic            ustop_next;

  logic [PS_W-1:0] ps_count;
  logic            ps_tick;

  logic        gctrl_wr;
  logic        ucnt_wr;
  logic        uprd_wr;
  logic        uena_wr;
  logic [31:0] gctrl_cur;
  logic [31:0] gctrl_new;
  logic [31:0] ucnt_new;
  logic [31:0] uprd_new;
  logic [31:0] uena_new;
  logic [31:0] stat_rd;
  logic        ena_live;
  logic        count_en;
  logic        ucnt_match;
  logic        ucnt_step;
  logic        ucnt_wrap;

  // ==========================================================
  // Bus slave
  tgc_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_hit  (wr_hit),
    .rd_data (rd_data),
    .rd_hit  (rd_hit)
  );

  assign wr_hit = is_mapped(wr_addr);
  assign rd_hit = is_mapped(araddr);

  // ==========================================================
  // Write decode
  assign gctrl_wr = wr_en && (wr_addr == `TGC_OFF_GCTRL);
  assign ucnt_wr  = wr_en && (wr_addr == `TGC_OFF_UCNT);
  assign uprd_wr  = wr_en && (wr_addr == `TGC_OFF_UPRD);
  assign uena_wr  = wr_en && (wr_addr == `TGC_OFF_UENA);

  // Live prescale count shows in the read-only field
  assign gctrl_cur = {16'h0000, ps_count, pslim_reg, 4'h0,
                      mode_reg, urun_reg, lrun_reg};
  assign gctrl_new = merge(gctrl_cur, wr_data, wr_strb);
  assign ucnt_new  = merge(ucnt_reg, wr_data, wr_strb);
  assign uprd_new  = merge(uprd_reg, wr_data, wr_strb);
  assign uena_new  = merge({30'h0, uena_reg}, wr_data, wr_strb);
  assign stat_rd   = {28'h0000_000, wdog_active, count_en,
                      ps_tick, ustop_reg};

  assign rd_data =
    (araddr == `TGC_OFF_GCTRL) ? gctrl_cur :
    (araddr == `TGC_OFF_UCNT)  ? ucnt_reg :
    (araddr == `TGC_OFF_UPRD)  ? uprd_reg :
    (araddr == `TGC_OFF_UENA)  ? {30'h0, uena_reg} :
    (araddr == `TGC_OFF_STAT)  ? stat_rd : 32'h0000_0000;

  // ==========================================================
  // Upper half counting
  // reserved enable code counts as off
  assign ena_live = (uena_reg == TGC_ENA_ONCE) ||
                    (uena_reg == TGC_ENA_CONT);
  assign count_en = urun_reg && (mode_reg == TGC_MODE_DUAL_UNCH) &&
                    ena_live && !ustop_reg;
  assign ucnt_match = (ucnt_reg == uprd_reg);
  // step on the tick after match
  assign ucnt_step  = ps_tick && count_en;
  assign ucnt_wrap  = ucnt_match && (uena_reg == TGC_ENA_CONT);

  // run bit low forces counter to zero
  assign ucnt_next =
    !urun_reg               ? `TGC_UCNT_RST :
    ucnt_wr                 ? ucnt_new :
    (ucnt_step && ucnt_wrap) ? `TGC_UCNT_RST :
    (ucnt_step && !ucnt_match) ? 32'(ucnt_reg + 1'b1) : ucnt_reg;

  // one-time mode stops on period match
  // Stop beats an enable-mode write landing in the same cycle
  assign ustop_next =
    !urun_reg ? 1'b0 :
    (count_en && (uena_reg == TGC_ENA_ONCE) && ucnt_match) ? 1'b1 :
    uena_wr ? 1'b0 :
    ustop_reg;

  tgc_prescale #(
    .W (PS_W)
  ) u_prescale (
    .aclk    (aclk),
    .aresetn (aresetn),
    .en      (count_en),
    .clr     (!urun_reg),
    .limit   (pslim_reg),
    .count   (ps_count),
    .tick    (ps_tick)
  );

  // ==========================================================
  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pslim_reg <= `TGC_PSLIM_RST;
      mode_reg  <= TGC_MODE_GP64;
      urun_reg  <= 1'b0;
      lrun_reg  <= 1'b0;
    end else if (gctrl_wr) begin
      pslim_reg <= gctrl_new[`TGC_PSLIM_LSB +: PS_W];
      mode_reg  <= tgc_mode_e'(gctrl_new[`TGC_MODE_LSB +: 2]);
      // run bits locked by active watchdog
      if (!wdog_active) begin
        urun_reg <= gctrl_new[`TGC_URUN_BIT];
        lrun_reg <= gctrl_new[`TGC_LRUN_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uprd_reg  <= `TGC_UPRD_RST;
      uena_reg  <= TGC_ENA_OFF;
      ucnt_reg  <= `TGC_UCNT_RST;
      ustop_reg <= 1'b0;
    end else begin
      if (uprd_wr) begin
        uprd_reg <= uprd_new;
      end
      if (uena_wr) begin
        uena_reg <= tgc_ena_e'(uena_new[`TGC_UENA_LSB +: 2]);
      end
      ucnt_reg  <= ucnt_next;
      ustop_reg <= ustop_next;
    end
  end

  // ==========================================================
  // Outputs
  assign timer_mode    = mode_reg;
  // upper half released by its run bit
  assign upper_run     = urun_reg;
  // lower half held while its run bit is low
  assign lower_run     = lrun_reg;
  assign upper_count   = ucnt_reg;
  assign upper_stopped = ustop_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence pre_match_s;
    count_en && (ps_count == pslim_reg) && !ucnt_match && !ucnt_wr;
  endsequence

  sequence tick_clean_s;
    ps_tick && count_en && !ucnt_match && !ucnt_wr && !gctrl_wr;
  endsequence

  upper_step_a: assert property (
    pre_match_s ##1 tick_clean_s |=> ucnt_reg == 32'($past(ucnt_reg) + 1))
    else $error("upper counter missed its step after prescale match");

  once_stop_a: assert property (
    count_en && (uena_reg == TGC_ENA_ONCE) && ucnt_match
    |=> ustop_reg && !count_en)
    else $error("one-time upper timer did not stop at period");

  cont_wrap_a: assert property (
    ucnt_step && ucnt_wrap && urun_reg && !ucnt_wr |=> ucnt_reg == '0)
    else $error("continuous upper counter did not clear after period");

  mode_sel_a: assert property (
    gctrl_wr && wr_strb[0]
    |=> timer_mode == tgc_mode_e'($past(wr_data[3:2])))
    else $error("mode field not taken from write");

  upper_hold_a: assert property (
    !urun_reg |=> (ucnt_reg == '0) && !ustop_reg)
    else $error("upper half not held in reset");

  lower_run_a: assert property (
    gctrl_wr && wr_strb[0] && !wdog_active
    |=> lower_run == $past(wr_data[0]))
    else $error("lower run bit not applied");

  wdog_lock_a: assert property (
    gctrl_wr && wdog_active |=> $stable(upper_run) && $stable(lower_run))
    else $error("run bit changed in active watchdog state");

  unch_only_a: assert property (
    urun_reg && !ucnt_wr && ((mode_reg != TGC_MODE_DUAL_UNCH) || !ena_live)
    |=> $stable(ucnt_reg))
    else $error("upper counter moved outside unchained enable");

endmodule

/* sim/timer_global_control_test.sv */
// Self-checking bench for the timer global control block.
// Assumes tgc_top, tgc_pkg and tgc_map.svh are compiled ahead of it.
`include "tgc_map.svh"

module timer_global_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import tgc_pkg::*;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, wdog_active = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata, upper_count;
  wire         lower_run, upper_run, upper_stopped;
  tgc_mode_e   timer_mode;
  int          n_fail = 0, samples_checked = 0, cyc = 0;
  logic [31:0] rd;
  logic [1:0]  rs;

  tgc_top uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wdog_active(wdog_active), .timer_mode(timer_mode),
    .lower_run(lower_run), .upper_run(upper_run),
    .upper_count(upper_count), .upper_stopped(upper_stopped)
  );

  // ==========================================================
  // Clock and timeout
  always #50 aclk = ~aclk;

  // Generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      $display("MISMATCH timeout expected done seen hang");
      test_done();
    end
  end

  // ==========================================================
  // Shared helpers
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready is sampled before the edge's own updates land
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    logic aw_p, w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && awready === 1'b1) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready === 1'b1) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, 4'hf, rs);
    check("bresp", {30'h0, rs}, 32'h0);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge aclk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_reset();
    for (int i = 0; i < 5; i++) begin
      axi_rd(8'(i * 4), rd, rs);
      check("reset value", rd, 32'h0);
      check("rresp", {30'h0, rs}, 32'h0);
    end
    axi_rd(8'h14, rd, rs);
    check("unmapped rdata", rd, 32'h0);
    check("unmapped rresp", {30'h0, rs}, 32'h2);
    axi_wr(8'h14, 32'hffff_ffff, 4'hf, rs);
    check("unmapped bresp", {30'h0, rs}, 32'h2);
    $display("test_reset done");
  endtask

  task automatic test_fields();
    logic [31:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 32'(i);
      wr(`TGC_OFF_GCTRL, 32'hffff_00f0 | (m << 8) | (m << 2) | m);
      cycles(1);
      check("timer_mode", {30'h0, timer_mode}, m);
      check("lower_run", {31'h0, lower_run}, m & 1);
      check("upper_run", {31'h0, upper_run}, m >> 1);
      axi_rd(`TGC_OFF_GCTRL, rd, rs);
      check("gctrl fields", rd & 32'hffff_0fff, (m << 8) | (m << 2) | m);
    end
    wr(`TGC_OFF_UPRD, 32'h1122_3344);
    axi_wr(`TGC_OFF_UPRD, 32'haaaa_aaaa, 4'h2, rs);
    axi_rd(`TGC_OFF_UPRD, rd, rs);
    check("strobe merge", rd, 32'h1122_aa44);
    $display("test_fields done");
  endtask

  task automatic test_once();
    int n;
    wr(`TGC_OFF_GCTRL, 32'h0);
    wr(`TGC_OFF_UCNT, 32'h0);
    wr(`TGC_OFF_UPRD, 32'h3);
    wr(`TGC_OFF_UENA, 32'h1);
    wr(`TGC_OFF_GCTRL, 32'h0000_0207);
    while (upper_count !== 32'h1) @(negedge aclk);
    n = 0;
    while (upper_count !== 32'h2) begin
      @(negedge aclk);
      n++;
    end
    check("step spacing", 32'(n), 32'h3);
    while (upper_stopped !== 1'b1) @(negedge aclk);
    check("stop count", upper_count, 32'h3);
    cycles(10);
    check("held count", upper_count, 32'h3);
    check("still stopped", {31'h0, upper_stopped}, 32'h1);
    axi_rd(`TGC_OFF_STAT, rd, rs);
    check("status", rd & 32'hd, 32'h1);
    $display("test_once done");
  endtask

  task automatic test_cont();
    logic [31:0] seq [5] = '{32'h2, 32'h0, 32'h1, 32'h2, 32'h0};
    logic [31:0] g [3] = '{32'h7, 32'h7, 32'h3};
    logic [31:0] e [3] = '{32'h0, 32'h3, 32'h2};
    logic [31:0] c;
    wr(`TGC_OFF_GCTRL, 32'h0000_0f04);
    axi_rd(`TGC_OFF_UCNT, rd, rs);
    check("count in reset", rd, 32'h0);
    axi_rd(`TGC_OFF_GCTRL, rd, rs);
    check("prescale in reset", rd & 32'hf000, 32'h0);
    check("stop cleared", {31'h0, upper_stopped}, 32'h0);
    wr(`TGC_OFF_UPRD, 32'h2);
    wr(`TGC_OFF_UENA, 32'h2);
    wr(`TGC_OFF_GCTRL, 32'h0000_0007);
    while (upper_count !== 32'h1) @(negedge aclk);
    for (int i = 0; i < 5; i++) begin
      @(negedge aclk);
      check("wrap sequence", upper_count, seq[i]);
    end
    // Counting stops for enable off, reserved enable and mode TGC_MODE_GP64
    for (int i = 0; i < 3; i++) begin
      wr(`TGC_OFF_UENA, e[i]);
      wr(`TGC_OFF_GCTRL, g[i]);
      cycles(1);
      c = upper_count;
      cycles(6);
      check("count held", upper_count, c);
    end
    $display("test_cont done");
  endtask

  task automatic test_wdog();
    wr(`TGC_OFF_GCTRL, 32'h3);
    @(posedge aclk);
    wdog_active <= 1'b1;
    wr(`TGC_OFF_GCTRL, 32'h8);
    cycles(1);
    check("wd upper_run", {31'h0, upper_run}, 32'h1);
    check("wd lower_run", {31'h0, lower_run}, 32'h1);
    check("wd mode", {30'h0, timer_mode}, 32'h2);
    axi_rd(`TGC_OFF_STAT, rd, rs);
    check("wd status", rd & 32'h8, 32'h8);
    @(posedge aclk);
    wdog_active <= 1'b0;
    wr(`TGC_OFF_GCTRL, 32'h1);
    cycles(1);
    check("upper off", {31'h0, upper_run}, 32'h0);
    check("lower on", {31'h0, lower_run}, 32'h1);
    wr(`TGC_OFF_GCTRL, 32'h2);
    cycles(1);
    check("lower off", {31'h0, lower_run}, 32'h0);
    $display("test_wdog done");
  endtask

  // ==========================================================
  // Verdict
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset();
    test_fields();
    test_once();
    test_cont();
    test_wdog();
    test_done();
  end

endmodule
